// file: common/rsf_pkg.sv
package rsf_pkg;
   // Register byte offsets
   localparam logic [11:0] RSF_OFF_CTRL = 12'h008;
   localparam logic [11:0] RSF_OFF_STS = 12'h00c;
   localparam logic [11:0] RSF_OFF_ALARM_A = 12'h01c;
   localparam logic [11:0] RSF_OFF_WPROT = 12'h024;
   localparam logic [11:0] RSF_OFF_SHIFT = 12'h02c;
   localparam logic [11:0] RSF_OFF_CAL = 12'h03c;
   localparam logic [11:0] RSF_OFF_INT_STS = 12'h040;
   localparam logic [11:0] RSF_OFF_INT_MASK = 12'h044;

   // Reset values
   localparam logic [31:0] RSF_STS_RESET = 32'h0000_0007;
   localparam logic [31:0] RSF_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] RSF_ALARM_A_RESET = 32'h0000_0000;
   localparam logic [31:0] RSF_SHIFT_RESET = 32'h0000_0000;
   localparam logic [31:0] RSF_CAL_RESET = 32'h0000_0000;
   localparam logic [3:0] RSF_INT_RESET = 4'h0;

   // Status field positions
   localparam int RSF_STS_ALRW = 0;
   localparam int RSF_STS_SHIFTP = 3;
   localparam int RSF_STS_CALINIT = 4;
   localparam int RSF_STS_SYNC = 5;
   localparam int RSF_STS_INITRDY = 6;
   localparam int RSF_STS_INITREQ = 7;
   localparam int RSF_STS_ALRM = 8;
   localparam int RSF_STS_TS = 11;
   localparam int RSF_STS_TSOVR = 12;
   localparam int RSF_STS_TAMP = 13;
   localparam int RSF_STS_RECAL = 16;

   // Control field positions
   localparam int RSF_CTRL_BYPASS = 5;
   localparam int RSF_CTRL_ALARM_ENABLE_CTL = 8;

   // Interrupt status and mask field positions
   localparam int RSF_INT_W = 4;
   localparam int RSF_INT_ALARM = 0;
   localparam int RSF_INT_TS = 1;
   localparam int RSF_INT_TSOVR = 2;
   localparam int RSF_INT_TAMP = 3;

   localparam int RSF_KEY_W = 8;

   typedef enum {RSF_WP_LOCKED, RSF_WP_HALF, RSF_WP_OPEN} rsf_wp_e;
endpackage

// file: rtl/rsf_pin_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with rising edge pulse on the synchronised level
module rsf_pin_sync (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic pin_i,
   output logic rise_o
);
   logic meta;
   logic stable;
   logic stable_d;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         meta <= 1'b0;
         stable <= 1'b0;
         stable_d <= 1'b0;
      end else begin
         meta <= pin_i;
         stable <= meta;
         stable_d <= stable;
      end
   end

   // Edge taken only after the second stage
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         rise_o <= 1'b0;
      end else begin
         rise_o <= stable & ~stable_d;
      end
   end
endmodule

// file: rtl/rsf_status_flags.sv
`timescale 1ns/1ps
// Behaviour
// [RL1] Status register is write protected except bits 13:8.
// [RL2] Power-on reset loads status 0x00000007; system reset leaves it alone.
// [RL3] Alarm-writable set while alarm disabled; cleared in init mode.
// [RL4] Shift-pending set on shift write, cleared when shift done; writes ignored.
// [RL5] Calendar-initialized flag set while date year is nonzero.
// [RL6] Shadow-synced set on shadow copy; cleared while shift pending or bypass.
// [RL7] Shadow-synced cleared in init mode by hardware or software zero.
// [RL8] Init-ready only in init state; only then calendar registers writable.
// [RL9] Init request stops counter; clearing it resumes from new values.
// [RL10] Alarm-match flag set when time and date equal alarm A.
// [RL11] Alarm-match flag cleared by software writing zero.
// [RL12] Timestamp flag set per timestamp event; cleared by writing zero.
// [RL13] Overflow set on timestamp event while timestamp flag set; write zero clears.
// [RL14] Software clears overflow after timestamp flag; device does not enforce.
// [RL15] Tamper flag set on tamper one input event; cleared by writing zero.
// [RL16] Calibration write sets recal-pending and locks calibration until applied.
// [RL17] Writing one to a write-zero-to-clear flag leaves it unchanged.
// [RL18] Bypass off reads shadow copies; bypass on reads live date.
// [RL19] Alarm enable zero disables alarm A, one enables it.
module rsf_status_flags
   import rsf_pkg::*;
#(
   parameter logic [RSF_KEY_W-1:0] WP_KEY_FIRST = 8'h5a,
   parameter logic [RSF_KEY_W-1:0] WP_KEY_SECOND = 8'ha5,
   parameter int YEAR_W = 8
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [YEAR_W-1:0] date_year_i,
   input wire logic alarm_match_i,
   input wire logic shadow_copy_i,
   input wire logic ts_event_i,
   input wire logic tamper_pin_i,
   input wire logic shift_done_i,
   input wire logic recal_done_i,
   output logic counter_stop_o,
   output logic calendar_write_en_o,
   output logic shadow_bypass_o,
   output logic alarm_enable_o,
   output logic [31:0] alarm_a_o,
   output logic shift_start_o,
   output logic [31:0] shift_value_o,
   output logic [31:0] cal_value_o,
   output logic irq_o
);

   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
      merge = (old & ~m) | (wd & m);
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == RSF_OFF_CTRL) || (a == RSF_OFF_STS) || (a == RSF_OFF_ALARM_A) ||
                  (a == RSF_OFF_WPROT) || (a == RSF_OFF_SHIFT) || (a == RSF_OFF_CAL) ||
                  (a == RSF_OFF_INT_STS) || (a == RSF_OFF_INT_MASK);
   endfunction

   logic [31:0] ctrl;
   logic [1:0] sts_rsvd;
   logic alarm_writable_flag;
   logic shift_pending_flag;
   logic calendar_initialized_flag;
   logic shadow_synced_flag;
   logic init_ready_flag;
   logic init_mode_request;
   logic alarm_match_flag;
   logic timestamp_flag;
   logic timestamp_overflow_flag;
   logic tamper_one_flag;
   logic recal_pending_flag;
   logic [RSF_INT_W-1:0] int_sts;
   logic [RSF_INT_W-1:0] int_mask;
   rsf_wp_e wp_state;
   logic tamper_rise;

   logic access;
   logic wr;
   logic [31:0] wmask;
   logic wp_open;
   logic wr_ctrl;
   logic wr_sts;
   logic wr_alarm;
   logic wr_wprot;
   logic wr_shift;
   logic wr_cal;
   logic wr_int_sts;
   logic wr_int_mask;
   logic [31:0] sts_word;
   logic [31:0] next_rdata;
   logic [RSF_INT_W-1:0] int_events;
   logic ts_hit;

   rsf_pin_sync u_tamper_sync (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .pin_i(tamper_pin_i),
      .rise_o(tamper_rise)
   );

   // APB slave: one wait state, so every access completes on its second access cycle
   assign access = psel_i & penable_i & pready_o;
   assign wr = access & pwrite_i & is_mapped(paddr_i);
   assign wmask = lane_mask(pstrb_i);
   assign wp_open = (wp_state == RSF_WP_OPEN);

   // [RL1] Protected decode
   assign wr_ctrl = wr & wp_open & (paddr_i == RSF_OFF_CTRL);
   assign wr_sts = wr & (paddr_i == RSF_OFF_STS);
   assign wr_wprot = wr & (paddr_i == RSF_OFF_WPROT);
   assign wr_shift = wr & wp_open & (paddr_i == RSF_OFF_SHIFT) & ~shift_pending_flag;
   assign wr_int_sts = wr & (paddr_i == RSF_OFF_INT_STS);
   assign wr_int_mask = wr & (paddr_i == RSF_OFF_INT_MASK);
   // [RL3] Alarm gate open
   assign wr_alarm = wr & wp_open & (paddr_i == RSF_OFF_ALARM_A) & (alarm_writable_flag | init_ready_flag);
   // [RL16] Calibration lock
   assign wr_cal = wr & wp_open & (paddr_i == RSF_OFF_CAL) & ~recal_pending_flag;

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= psel_i & penable_i & ~pready_o;
      end
   end

   always_comb begin
      sts_word = 32'h0000_0000;
      sts_word[RSF_STS_ALRW] = alarm_writable_flag;
      sts_word[RSF_STS_ALRW+2:RSF_STS_ALRW+1] = sts_rsvd;
      sts_word[RSF_STS_SHIFTP] = shift_pending_flag;
      sts_word[RSF_STS_CALINIT] = calendar_initialized_flag;
      sts_word[RSF_STS_SYNC] = shadow_synced_flag;
      sts_word[RSF_STS_INITRDY] = init_ready_flag;
      sts_word[RSF_STS_INITREQ] = init_mode_request;
      sts_word[RSF_STS_ALRM] = alarm_match_flag;
      sts_word[RSF_STS_TS] = timestamp_flag;
      sts_word[RSF_STS_TSOVR] = timestamp_overflow_flag;
      sts_word[RSF_STS_TAMP] = tamper_one_flag;
      sts_word[RSF_STS_RECAL] = recal_pending_flag;
   end

   // Key register reads as zero
   always_comb begin
      case (paddr_i)
         RSF_OFF_CTRL: next_rdata = ctrl;
         RSF_OFF_STS: next_rdata = sts_word;
         RSF_OFF_ALARM_A: next_rdata = alarm_a_o;
         RSF_OFF_SHIFT: next_rdata = shift_value_o;
         RSF_OFF_CAL: next_rdata = cal_value_o;
         RSF_OFF_INT_STS: next_rdata = {{(32-RSF_INT_W){1'b0}}, int_sts};
         RSF_OFF_INT_MASK: next_rdata = {{(32-RSF_INT_W){1'b0}}, int_mask};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the cycle before pready rises
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (psel_i & penable_i & ~pready_o) begin
         prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
         pslverr_o <= ~is_mapped(paddr_i);
      end else begin
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end
   end

   // Two key writes unlock; any other key write locks again
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wp_state <= RSF_WP_LOCKED;
      end else if (wr_wprot & pstrb_i[0]) begin
         case (wp_state)
            RSF_WP_LOCKED: wp_state <= (pwdata_i[RSF_KEY_W-1:0] == WP_KEY_FIRST) ? RSF_WP_HALF : RSF_WP_LOCKED;
            RSF_WP_HALF: wp_state <= (pwdata_i[RSF_KEY_W-1:0] == WP_KEY_SECOND) ? RSF_WP_OPEN : RSF_WP_LOCKED;
            default: wp_state <= RSF_WP_LOCKED;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ctrl <= RSF_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= merge(ctrl, pwdata_i, wmask);
      end
   end

   // [RL18] Bypass select
   // [RL19] Alarm enable
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         shadow_bypass_o <= RSF_CTRL_RESET[RSF_CTRL_BYPASS];
         alarm_enable_o <= RSF_CTRL_RESET[RSF_CTRL_ALARM_ENABLE_CTL];
      end else begin
         shadow_bypass_o <= ctrl[RSF_CTRL_BYPASS];
         alarm_enable_o <= ctrl[RSF_CTRL_ALARM_ENABLE_CTL];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         alarm_a_o <= RSF_ALARM_A_RESET;
      end else if (wr_alarm) begin
         alarm_a_o <= merge(alarm_a_o, pwdata_i, wmask);
      end
   end

   // [RL2] Power-on values only; no other reset reaches these flags
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sts_rsvd <= RSF_STS_RESET[RSF_STS_ALRW+2:RSF_STS_ALRW+1];
      end else begin
         sts_rsvd <= sts_rsvd;
      end
   end

   // [RL9] Init request, protected
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         init_mode_request <= RSF_STS_RESET[RSF_STS_INITREQ];
      end else if (wr_sts & wp_open & pstrb_i[0]) begin
         init_mode_request <= pwdata_i[RSF_STS_INITREQ];
      end
   end

   // [RL8] Ready follows request one cycle later
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         init_ready_flag <= RSF_STS_RESET[RSF_STS_INITRDY];
      end else begin
         init_ready_flag <= init_mode_request;
      end
   end

   // [RL9] Counter stop and calendar write enable
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         counter_stop_o <= 1'b0;
         calendar_write_en_o <= 1'b0;
      end else begin
         counter_stop_o <= init_mode_request;
         calendar_write_en_o <= init_mode_request & init_ready_flag;
      end
   end

   // [RL3] Alarm writable tracking
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         alarm_writable_flag <= RSF_STS_RESET[RSF_STS_ALRW];
      end else begin
         alarm_writable_flag <= ~ctrl[RSF_CTRL_ALARM_ENABLE_CTL] & ~init_mode_request;
      end
   end

   // [RL5] Year nonzero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         calendar_initialized_flag <= RSF_STS_RESET[RSF_STS_CALINIT];
      end else begin
         calendar_initialized_flag <= (date_year_i != '0);
      end
   end

   // [RL4] Shift pending; set wins over done
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         shift_pending_flag <= RSF_STS_RESET[RSF_STS_SHIFTP];
      end else begin
         shift_pending_flag <= wr_shift | (shift_pending_flag & ~shift_done_i);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         shift_value_o <= RSF_SHIFT_RESET;
         shift_start_o <= 1'b0;
      end else begin
         shift_start_o <= wr_shift;
         if (wr_shift) begin
            shift_value_o <= merge(shift_value_o, pwdata_i, wmask);
         end
      end
   end

   // [RL6] Hardware hold-off outranks a copy
   // [RL7] Cleared in init mode, or by software zero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         shadow_synced_flag <= RSF_STS_RESET[RSF_STS_SYNC];
      end else if (shift_pending_flag | ctrl[RSF_CTRL_BYPASS] | init_mode_request) begin
         shadow_synced_flag <= 1'b0;
      end else begin
         shadow_synced_flag <= shadow_copy_i |
            (shadow_synced_flag & ~(wr_sts & wp_open & pstrb_i[0] & ~pwdata_i[RSF_STS_SYNC]));
      end
   end

   // [RL10] Match counts only with alarm enabled
   // [RL11] Write zero clears
   // [RL17] Write one keeps
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         alarm_match_flag <= RSF_STS_RESET[RSF_STS_ALRM];
      end else begin
         alarm_match_flag <= (alarm_match_i & ctrl[RSF_CTRL_ALARM_ENABLE_CTL]) |
            (alarm_match_flag & ~(wr_sts & pstrb_i[1] & ~pwdata_i[RSF_STS_ALRM]));
      end
   end

   // [RL12] Timestamp flag
   // [RL13] Overflow on event while flag set
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         timestamp_flag <= RSF_STS_RESET[RSF_STS_TS];
         timestamp_overflow_flag <= RSF_STS_RESET[RSF_STS_TSOVR];
      end else begin
         timestamp_flag <= ts_event_i |
            (timestamp_flag & ~(wr_sts & pstrb_i[1] & ~pwdata_i[RSF_STS_TS]));
         timestamp_overflow_flag <= ts_hit |
            (timestamp_overflow_flag & ~(wr_sts & pstrb_i[1] & ~pwdata_i[RSF_STS_TSOVR]));
      end
   end

   // Clear order between the two is left to software
   assign ts_hit = ts_event_i & timestamp_flag;

   // [RL15] Tamper edge from the synchronised pin
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tamper_one_flag <= RSF_STS_RESET[RSF_STS_TAMP];
      end else begin
         tamper_one_flag <= tamper_rise |
            (tamper_one_flag & ~(wr_sts & pstrb_i[1] & ~pwdata_i[RSF_STS_TAMP]));
      end
   end

   // [RL16] Recal pending until applied; set wins
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         recal_pending_flag <= RSF_STS_RESET[RSF_STS_RECAL];
      end else begin
         recal_pending_flag <= wr_cal | (recal_pending_flag & ~recal_done_i);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         cal_value_o <= RSF_CAL_RESET;
      end else if (wr_cal) begin
         cal_value_o <= merge(cal_value_o, pwdata_i, wmask);
      end
   end

   assign int_events[RSF_INT_ALARM] = alarm_match_i & ctrl[RSF_CTRL_ALARM_ENABLE_CTL];
   assign int_events[RSF_INT_TS] = ts_event_i;
   assign int_events[RSF_INT_TSOVR] = ts_hit;
   assign int_events[RSF_INT_TAMP] = tamper_rise;

   // Sticky, write one to clear; a new event beats the clear
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         int_sts <= RSF_INT_RESET;
      end else begin
         int_sts <= int_events |
            (int_sts & ~(wr_int_sts & pstrb_i[0] ? pwdata_i[RSF_INT_W-1:0] : RSF_INT_RESET));
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         int_mask <= RSF_INT_RESET;
      end else if (wr_int_mask & pstrb_i[0]) begin
         int_mask <= pwdata_i[RSF_INT_W-1:0];
      end
   end

   // Registered, so the line trails the status bit by one cycle
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(int_sts & int_mask);
      end
   end
endmodule

// file: test/rsf_status_flags_checker.sv
`timescale 1ns/1ps
module rsf_status_flags_checker
   import rsf_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic counter_stop_o,
   input wire logic calendar_write_en_o,
   input wire logic shadow_bypass_o,
   input wire logic alarm_enable_o,
   input wire logic shift_start_o
);
   logic acc_done;
   logic wr_ctrl;
   logic wr_sts;
   logic wr_shift;
   assign acc_done = psel_i && penable_i && pready_o;
   assign wr_ctrl = acc_done && pwrite_i && paddr_i == RSF_OFF_CTRL;
   assign wr_sts = acc_done && pwrite_i && paddr_i == RSF_OFF_STS;
   assign wr_shift = acc_done && pwrite_i && paddr_i == RSF_OFF_SHIFT;
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);
   sequence access_open;
      psel_i && $rose(penable_i);
   endsequence
   sequence one_wait;
      !pready_o ##1 pready_o;
   endsequence
   ready_wait_a: assert property (access_open |-> one_wait)
      else $error("access not ended after one wait state");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data not zero outside ready");
   unmapped_err_a: assert property (acc_done && paddr_i == 12'h100 |-> pslverr_o)
      else $error("no error on unmapped address");
   mapped_ok_a: assert property (acc_done && paddr_i == RSF_OFF_STS |-> !pslverr_o)
      else $error("error on status access");
   write_en_a: assert property ($rose(calendar_write_en_o) |-> counter_stop_o)
      else $error("calendar writable outside init");
   stop_cause_a: assert property ($changed(counter_stop_o) |->
      $past(wr_sts) || $past(wr_sts, 2) || $past(wr_sts, 3) || $past(wr_sts, 4))
      else $error("counter stop moved without status write");
   alarm_enable_ctl_cause_a: assert property ($changed(alarm_enable_o) |->
      $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
      else $error("alarm enable moved without control write");
   bypass_cause_a: assert property ($changed(shadow_bypass_o) |->
      $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
      else $error("bypass moved without control write");
   shift_pulse_a: assert property (shift_start_o |->
      ($past(wr_shift) || $past(wr_shift, 2)) ##1 !shift_start_o)
      else $error("shift start without write or too long");
endmodule

bind rsf_status_flags rsf_status_flags_checker u_chk (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .counter_stop_o(counter_stop_o), .calendar_write_en_o(calendar_write_en_o),
   .shadow_bypass_o(shadow_bypass_o), .alarm_enable_o(alarm_enable_o), .shift_start_o(shift_start_o));

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import rsf_pkg::*;
;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} rsf_exp_s;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0] pstrb_i = 4'hf;
   logic [7:0] date_year_i = 8'h00;
   logic alarm_match_i = 1'b0;
   logic shadow_copy_i = 1'b0;
   logic ts_event_i = 1'b0;
   logic tamper_pin_i = 1'b0;
   logic shift_done_i = 1'b0;
   logic recal_done_i = 1'b0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic counter_stop_o;
   logic calendar_write_en_o;
   logic shadow_bypass_o;
   logic alarm_enable_o;
   logic [31:0] alarm_a_o;
   logic shift_start_o;
   logic [31:0] shift_value_o;
   logic [31:0] cal_value_o;
   logic irq_o;
   int n_fail = 0;
   int total_checks = 0;
   rsf_exp_s expq[$];
   rsf_exp_s mon_x;
   logic [31:0] r1;
   logic [31:0] r2;

   always #12.5 mclk_i = ~mclk_i;

   rsf_status_flags DUT (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .date_year_i(date_year_i), .alarm_match_i(alarm_match_i),
      .shadow_copy_i(shadow_copy_i), .ts_event_i(ts_event_i), .tamper_pin_i(tamper_pin_i),
      .shift_done_i(shift_done_i), .recal_done_i(recal_done_i), .counter_stop_o(counter_stop_o),
      .calendar_write_en_o(calendar_write_en_o), .shadow_bypass_o(shadow_bypass_o),
      .alarm_enable_o(alarm_enable_o), .alarm_a_o(alarm_a_o), .shift_start_o(shift_start_o),
      .shift_value_o(shift_value_o), .cal_value_o(cal_value_o), .irq_o(irq_o));

   task end_of_test;
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Master holds the request until ready is seen; a missing answer ends the run
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      i = 0;
      do begin
         @(posedge mclk_i);
         i++;
      end while (pready_o !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_fail++;
         end_of_test();
      end
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
      expq.push_back('{d, m, e});
      apb(1'b0, a, 32'h0);
   endtask

   task rs(input logic [31:0] d);
      rd(RSF_OFF_STS, d, 32'hffffffff, 1'b0);
   endtask

   task pulse(input int k);
      @(posedge mclk_i);
      case (k)
         0: ts_event_i <= 1'b1;
         1: alarm_match_i <= 1'b1;
         2: shadow_copy_i <= 1'b1;
         3: shift_done_i <= 1'b1;
         default: recal_done_i <= 1'b1;
      endcase
      @(posedge mclk_i);
      {ts_event_i, alarm_match_i, shadow_copy_i, shift_done_i, recal_done_i} <= 5'h00;
   endtask

   // Read data stand only in the ready cycle, so they are taken at the edge that ends it
   always @(posedge mclk_i) begin
      if (pready_o === 1'b1 && psel_i && penable_i && !pwrite_i) begin
         check("read expected", 32'(expq.size() > 0), 32'h1);
         mon_x = expq.pop_front();
         check("read data", prdata_o & mon_x.m, mon_x.d);
         check("slave error", 32'(pslverr_o), 32'(mon_x.e));
      end
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      n_fail++;
      end_of_test();
   end

   initial begin
      void'($urandom(32'hb45e));
      repeat (16) @(posedge mclk_i);
      srst_i <= 1'b0;
      rs(32'h7);
      rd(12'h100, 32'h0, 32'h0, 1'b1);
      apb(1'b1, RSF_OFF_STS, 32'h80);
      rs(32'h7);
      date_year_i <= 8'($urandom_range(255, 1));
      rs(32'h17);
      pulse(0);
      rs(32'h817);
      pulse(0);
      rs(32'h1817);
      rd(RSF_OFF_INT_STS, 32'h6, 32'hf, 1'b0);
      apb(1'b1, RSF_OFF_INT_MASK, 32'h2);
      repeat (2) @(negedge mclk_i);
      check("irq on", 32'(irq_o), 32'h1);
      apb(1'b1, RSF_OFF_STS, 32'hffffffff);
      rs(32'h1817);
      apb(1'b1, RSF_OFF_STS, 32'hfffff7ff);
      rs(32'h1017);
      apb(1'b1, RSF_OFF_INT_STS, 32'h2);
      repeat (2) @(negedge mclk_i);
      check("irq off", 32'(irq_o), 32'h0);
      apb(1'b1, RSF_OFF_STS, 32'hffffefff);
      rs(32'h17);
      tamper_pin_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      rs(32'h2017);
      apb(1'b1, RSF_OFF_STS, 32'hffffdfff);
      tamper_pin_i <= 1'b0;
      rs(32'h17);
      pulse(1);
      rs(32'h17);
      r1 = $urandom;
      apb(1'b1, RSF_OFF_ALARM_A, r1);
      @(negedge mclk_i);
      check("alarm a locked", alarm_a_o, RSF_ALARM_A_RESET);
      apb(1'b1, RSF_OFF_WPROT, 32'h5a);
      apb(1'b1, RSF_OFF_WPROT, 32'ha5);
      apb(1'b1, RSF_OFF_ALARM_A, r1);
      @(negedge mclk_i);
      check("alarm a written", alarm_a_o, r1);
      apb(1'b1, RSF_OFF_CTRL, 32'h100);
      rs(32'h16);
      check("alarm enable", 32'(alarm_enable_o), 32'h1);
      apb(1'b1, RSF_OFF_ALARM_A, ~r1);
      pulse(1);
      rs(32'h116);
      check("alarm a held", alarm_a_o, r1);
      apb(1'b1, RSF_OFF_STS, 32'hfffffe7f);
      rs(32'h16);
      apb(1'b1, RSF_OFF_CTRL, 32'h0);
      r2 = $urandom;
      apb(1'b1, RSF_OFF_SHIFT, r2);
      rs(32'h1f);
      check("shift value", shift_value_o, r2);
      pulse(2);
      apb(1'b1, RSF_OFF_STS, 32'h0);
      rs(32'h1f);
      pulse(3);
      rs(32'h17);
      pulse(2);
      rs(32'h37);
      apb(1'b1, RSF_OFF_CTRL, 32'h20);
      rs(32'h17);
      check("bypass", 32'(shadow_bypass_o), 32'h1);
      apb(1'b1, RSF_OFF_CTRL, 32'h0);
      pulse(2);
      apb(1'b1, RSF_OFF_STS, 32'ha0);
      rs(32'hd6);
      check("counter stop", 32'(counter_stop_o), 32'h1);
      check("calendar write", 32'(calendar_write_en_o), 32'h1);
      apb(1'b1, RSF_OFF_STS, 32'h0);
      rs(32'h17);
      check("counter run", 32'(counter_stop_o), 32'h0);
      apb(1'b1, RSF_OFF_CAL, r1);
      rs(32'h10017);
      apb(1'b1, RSF_OFF_CAL, ~r1);
      @(negedge mclk_i);
      check("cal locked", cal_value_o, r1);
      pulse(4);
      rs(32'h17);
      end_of_test();
   end
endmodule
